// File: logic/tsi_pkg.sv
package tsi_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int LANES = 3;
    localparam int MARKER_W = 64;
    localparam int MARKER_WORDS = 2 * LANES;
    localparam int BEAT_BYTES_W = 5;
    localparam int GOOD_BYTES_W = 14;
    localparam int BIN_COUNT = 9;
    localparam int ADDR_W = 8;
    localparam int FRAME_CNT_W = 16;
    localparam int MARK_PERIOD_DEFAULT = 16384;

    // ----------------------------------------------------------------
    // Histogram bin limits, inclusive
    // ----------------------------------------------------------------
    localparam logic [GOOD_BYTES_W-1:0] BIN_LO [0:BIN_COUNT-1] = '{
        14'h0040, 14'h0041, 14'h0080, 14'h0100, 14'h0200,
        14'h0400, 14'h05ef, 14'h05f3, 14'h060d};
    localparam logic [GOOD_BYTES_W-1:0] BIN_HI [0:BIN_COUNT-1] = '{
        14'h0040, 14'h007f, 14'h00ff, 14'h01ff, 14'h03ff,
        14'h05ee, 14'h05f2, 14'h060c, 14'h07ff};

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_LAST_LEN = 8'h08;
    localparam logic [ADDR_W-1:0] REG_MARK_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] REG_MARK_END = 8'h24;
    localparam int CTRL_MAC_BIT = 0;
    localparam int CTRL_PORT_RST_BIT = 1;
    localparam int STATUS_IN_FRAME_BIT = 16;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
    localparam logic [31:0] MARK_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // AHB-Lite codes
    // ----------------------------------------------------------------
    localparam logic HRESP_OKAY = 1'b0;
    localparam int HTRANS_ACTIVE_BIT = 1;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic eop;
        logic err;
        logic [BEAT_BYTES_W-1:0] bytes;
    } tsi_beat_s;

    typedef struct packed {
        logic totalPkt;
        logic [BEAT_BYTES_W-1:0] totalBytes;
        logic goodPkt;
        logic [GOOD_BYTES_W-1:0] goodBytes;
        logic [BIN_COUNT-1:0] hist;
    } tsi_stat_s;

    typedef logic [LANES-1:0][MARKER_W-1:0] tsi_lanes_t;

endpackage

// File: logic/tsi_marker_insert.sv
`timescale 1ns/1ns
module tsi_marker_insert #(
    parameter int PERIOD = tsi_pkg::MARK_PERIOD_DEFAULT
) (
    input wire logic clk,
    input wire logic reset,
    input wire tsi_pkg::tsi_lanes_t laneDataIn,
    input wire tsi_pkg::tsi_lanes_t markers,
    output tsi_pkg::tsi_lanes_t laneDataOut,
    output logic markerSlot
);
    import tsi_pkg::*;

    localparam int CNT_W = $clog2(PERIOD);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);

    initial begin
        if (PERIOD < 2) begin
            $error("tsi_marker_insert: PERIOD must be at least 2");
        end
    end

    // ----------------------------------------------------------------
    // Marker slot timing
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] slotCnt_r;
    wire slotNow = (slotCnt_r == LAST);
    wire [CNT_W-1:0] slotCnt_nxt = slotNow ? '0 : slotCnt_r + CNT_W'(1);

    always_ff @(posedge clk) begin
        if (reset) begin
            slotCnt_r <= '0;
            markerSlot <= 1'b0;
        end else begin
            slotCnt_r <= slotCnt_nxt;
            markerSlot <= slotNow;
        end
    end

    // ----------------------------------------------------------------
    // Per-lane substitution
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : gLane
            wire [MARKER_W-1:0] laneSel = slotNow ? markers[g] : laneDataIn[g];
            always_ff @(posedge clk) begin
                if (reset) begin
                    laneDataOut[g] <= '0;
                end else begin
                    laneDataOut[g] <= laneSel;
                end
            end
        end
    endgenerate

endmodule

// File: logic/tsi_tx_stats.sv
// Summary of operation
// - Lanes 1 to 3 each get their own 64-bit marker, inserted periodically.
// - Total packet increment pulses once per transmitted frame, good or bad.
// - Total byte increment shows the bytes transmitted in each cycle.
// - Good packet increment pulses once per error-free frame.
// - Good byte increment is 14 bits, whole frame length in one go.
// - Good byte increment is zero except at end of an error-free frame.
// - Histogram pulse for frames of exactly 64 bytes.
// - Histogram pulse for frames of 65 to 127 bytes.
// - Histogram pulse for frames of 128 to 255 bytes.
// - Histogram pulse for frames of 256 to 511 bytes.
// - Histogram pulse for frames of 512 to 1023 bytes.
// - Histogram pulse for frames of 1024 to 1518 bytes.
// - Histogram pulse for frames of 1519 to 1522 bytes.
// - Histogram pulse for frames of 1523 to 1548 bytes.
// - Histogram pulse for frames of 1549 to 2047 bytes.
// - Statistics outputs active only in full MAC mode; PCS-only holds them zero.
`timescale 1ns/1ns
module tsi_tx_stats #(
    parameter int MARK_PERIOD = tsi_pkg::MARK_PERIOD_DEFAULT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire tsi_pkg::tsi_beat_s txBeat,
    output tsi_pkg::tsi_stat_s statInc,
    input wire tsi_pkg::tsi_lanes_t laneDataIn,
    output tsi_pkg::tsi_lanes_t laneDataOut,
    output logic markerSlot
);
    import tsi_pkg::*;

    initial begin
        if (MARK_PERIOD < 2) begin
            $error("tsi_tx_stats: MARK_PERIOD must be at least 2");
        end
    end

    // ----------------------------------------------------------------
    // Register map checks
    // ----------------------------------------------------------------
    // Read words are fixed concatenations; a moved field must stop here
    initial begin
        if (LANES < 1) begin
            $error("tsi_tx_stats: at least one lane is needed");
        end
        if (MARKER_W != 2 * $bits(hwdata)) begin
            $error("tsi_tx_stats: a lane marker must be two bus words");
        end
        if (MARKER_WORDS != 2 * LANES) begin
            $error("tsi_tx_stats: each lane needs two marker words");
        end
        if ($clog2(MARKER_WORDS) > ADDR_W - 2) begin
            $error("tsi_tx_stats: marker index does not fit the decoded address");
        end
        if (ADDR_W > $bits(haddr)) begin
            $error("tsi_tx_stats: decoded address wider than the bus");
        end
        if ((REG_CTRL[1:0] | REG_STATUS[1:0] | REG_LAST_LEN[1:0]
            | REG_MARK_BASE[1:0]) != 2'b00) begin
            $error("tsi_tx_stats: registers must be word aligned");
        end
        if (REG_STATUS == REG_CTRL || REG_LAST_LEN == REG_CTRL
            || REG_LAST_LEN == REG_STATUS) begin
            $error("tsi_tx_stats: register offsets must be distinct");
        end
        if (int'(REG_MARK_END) != int'(REG_MARK_BASE) + 4 * (MARKER_WORDS - 1)) begin
            $error("tsi_tx_stats: marker window does not match the lane count");
        end
        if ((REG_CTRL >= REG_MARK_BASE && REG_CTRL <= REG_MARK_END)
            || (REG_STATUS >= REG_MARK_BASE && REG_STATUS <= REG_MARK_END)
            || (REG_LAST_LEN >= REG_MARK_BASE && REG_LAST_LEN <= REG_MARK_END)) begin
            $error("tsi_tx_stats: marker window overlaps the status words");
        end
        if (CTRL_MAC_BIT != 0 || CTRL_PORT_RST_BIT != 1) begin
            $error("tsi_tx_stats: control bits must sit at the bottom of the word");
        end
        if (CTRL_RESET[31:2] != '0) begin
            $error("tsi_tx_stats: control reset value has bits beyond the controls");
        end
        if (STATUS_IN_FRAME_BIT != FRAME_CNT_W || FRAME_CNT_W + 16 != $bits(hrdata)) begin
            $error("tsi_tx_stats: status word layout does not match its fields");
        end
        if (GOOD_BYTES_W + 18 != $bits(hrdata)) begin
            $error("tsi_tx_stats: last length word layout does not match its field");
        end
        if (HTRANS_ACTIVE_BIT > 1) begin
            $error("tsi_tx_stats: transfer type has only two bits");
        end
    end

    // ----------------------------------------------------------------
    // Frame length checks
    // ----------------------------------------------------------------
    initial begin
        if (BEAT_BYTES_W >= GOOD_BYTES_W) begin
            $error("tsi_tx_stats: frame length must be wider than a beat count");
        end
        // A saturated length must stay out of every bin
        if (BIN_HI[BIN_COUNT-1] == {GOOD_BYTES_W{1'b1}}) begin
            $error("tsi_tx_stats: top bin reaches the saturated length");
        end
    end

    // ----------------------------------------------------------------
    // Histogram bin checks
    // ----------------------------------------------------------------
    // Overlapping bins would pulse two outputs for one frame
    initial begin
        if (BIN_LO[0] == '0) begin
            $error("tsi_tx_stats: an empty frame would land in a bin");
        end
        for (int b = 0; b < BIN_COUNT; b++) begin
            if (BIN_LO[b] > BIN_HI[b]) begin
                $error("tsi_tx_stats: histogram bin limits reversed");
            end
            if (b > 0) begin
                if (BIN_LO[b] <= BIN_HI[b-1]) begin
                    $error("tsi_tx_stats: histogram bins overlap");
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [MARKER_WORDS-1:0][31:0] markWord_r;
    logic [FRAME_CNT_W-1:0] frameCnt_r;
    logic [GOOD_BYTES_W-1:0] lastLen_r;
    logic inFrame_r;

    wire macMode = ctrl_r[CTRL_MAC_BIT];
    wire portRst = ctrl_r[CTRL_PORT_RST_BIT];
    wire laneReset = reset | portRst;

    // ----------------------------------------------------------------
    // AHB-Lite address phase decode
    // ----------------------------------------------------------------
    logic wrPend_r;
    logic [ADDR_W-1:0] wrAddr_r;

    wire addrTake = hsel & htrans[HTRANS_ACTIVE_BIT] & hready;
    wire [ADDR_W-1:0] aAddr = haddr[ADDR_W-1:0];
    wire aMapped = (aAddr == REG_CTRL) | (aAddr == REG_STATUS) | (aAddr == REG_LAST_LEN)
        | ((aAddr >= REG_MARK_BASE) & (aAddr <= REG_MARK_END) & (aAddr[1:0] == 2'b00));
    wire [ADDR_W-1:0] aMarkOff = aAddr - REG_MARK_BASE;
    wire [ADDR_W-3:0] aMarkIdx = aMarkOff[ADDR_W-1:2];
    wire aIsMark = (aAddr >= REG_MARK_BASE) & (aAddr <= REG_MARK_END);

    wire [31:0] statusWord = {15'h0000, inFrame_r, frameCnt_r};
    wire [31:0] lastLenWord = {18'h00000, lastLen_r};
    wire [31:0] markRead = markWord_r[aMarkIdx[$clog2(MARKER_WORDS)-1:0]];
    wire [31:0] readSel =
        (aAddr == REG_CTRL) ? ctrl_r :
        (aAddr == REG_STATUS) ? statusWord :
        (aAddr == REG_LAST_LEN) ? lastLenWord :
        (aIsMark & aMapped) ? markRead : 32'h0000_0000;
    wire readTake = addrTake & ~hwrite;
    wire writeTake = addrTake & hwrite & aMapped;

    // ----------------------------------------------------------------
    // AHB-Lite data phase
    // ----------------------------------------------------------------
    wire [ADDR_W-1:0] wMarkOff = wrAddr_r - REG_MARK_BASE;
    wire [ADDR_W-3:0] wMarkIdx = wMarkOff[ADDR_W-1:2];
    wire wIsMark = (wrAddr_r >= REG_MARK_BASE) & (wrAddr_r <= REG_MARK_END);
    wire ctrlWr = wrPend_r & (wrAddr_r == REG_CTRL);
    // Markers only move while the port is held in reset
    wire markWrOk = wrPend_r & wIsMark & portRst;

    always_ff @(posedge clk) begin
        if (reset) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= '0;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end else begin
            wrPend_r <= writeTake;
            wrAddr_r <= aAddr;
            hrdata <= readTake ? readSel : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_r <= CTRL_RESET;
        end else if (ctrlWr) begin
            ctrl_r <= {30'h0000_0000, hwdata[CTRL_PORT_RST_BIT], hwdata[CTRL_MAC_BIT]};
        end
    end

    genvar w;
    generate
        for (w = 0; w < MARKER_WORDS; w++) begin : gMarkWord
            wire hit = markWrOk & (wMarkIdx == (ADDR_W-2)'(w));
            always_ff @(posedge clk) begin
                if (reset) begin
                    markWord_r[w] <= MARK_RESET;
                end else if (hit) begin
                    markWord_r[w] <= hwdata;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Lane marker insertion
    // ----------------------------------------------------------------
    tsi_lanes_t markers;
    genvar l;
    generate
        for (l = 0; l < LANES; l++) begin : gMarker
            assign markers[l] = {markWord_r[2*l+1], markWord_r[2*l]};
        end
    endgenerate

    tsi_marker_insert #(
        .PERIOD(MARK_PERIOD)
    ) uMarker (
        .clk(clk),
        .reset(laneReset),
        .laneDataIn(laneDataIn),
        .markers(markers),
        .laneDataOut(laneDataOut),
        .markerSlot(markerSlot)
    );

    // ----------------------------------------------------------------
    // Frame length and error tracking
    // ----------------------------------------------------------------
    logic [GOOD_BYTES_W-1:0] lenAcc_r;
    logic errSeen_r;

    wire beatTake = txBeat.valid & ~portRst;
    wire frameEnd = beatTake & txBeat.eop;
    // Saturate rather than wrap so oversize frames never fall into a bin
    wire [GOOD_BYTES_W:0] sumLen = {1'b0, lenAcc_r} + (GOOD_BYTES_W+1)'(txBeat.bytes);
    wire [GOOD_BYTES_W-1:0] frameLen = sumLen[GOOD_BYTES_W] ? '1 : sumLen[GOOD_BYTES_W-1:0];
    wire frameBad = errSeen_r | txBeat.err;
    wire statsOn = macMode;

    always_ff @(posedge clk) begin
        if (laneReset) begin
            lenAcc_r <= '0;
            errSeen_r <= 1'b0;
            inFrame_r <= 1'b0;
        end else if (beatTake) begin
            lenAcc_r <= txBeat.eop ? '0 : frameLen;
            errSeen_r <= txBeat.eop ? 1'b0 : frameBad;
            inFrame_r <= ~txBeat.eop;
        end
    end

    always_ff @(posedge clk) begin
        if (laneReset) begin
            frameCnt_r <= '0;
            lastLen_r <= '0;
        end else if (frameEnd) begin
            frameCnt_r <= frameCnt_r + FRAME_CNT_W'(1);
            lastLen_r <= frameLen;
        end
    end

    // ----------------------------------------------------------------
    // Increment outputs
    // ----------------------------------------------------------------
    logic [BIN_COUNT-1:0] binHit;
    genvar b;
    generate
        for (b = 0; b < BIN_COUNT; b++) begin : gBin
            assign binHit[b] = (frameLen >= BIN_LO[b]) & (frameLen <= BIN_HI[b]);
        end
    endgenerate

    wire endOn = frameEnd & statsOn;
    wire goodEnd = endOn & ~frameBad;
    tsi_stat_s stat_nxt;
    assign stat_nxt.totalPkt = endOn;
    assign stat_nxt.totalBytes = (beatTake & statsOn) ? txBeat.bytes : '0;
    assign stat_nxt.goodPkt = goodEnd;
    assign stat_nxt.goodBytes = goodEnd ? frameLen : '0;
    assign stat_nxt.hist = endOn ? binHit : '0;

    // Outside counters add this every cycle, so each pulse is exactly one cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            statInc <= '0;
        end else begin
            statInc <= stat_nxt;
        end
    end

endmodule

// File: testbench/tsi_tx_stats_props.sv
`timescale 1ns/1ns
module tsi_tx_stats_props
    import tsi_pkg::*;
#(
    parameter int MARK_PERIOD = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire tsi_pkg::tsi_beat_s txBeat,
    input wire tsi_pkg::tsi_stat_s statInc,
    input wire logic markerSlot
);
    // --------------------------------
    // Helpers
    // --------------------------------
    logic [BIN_COUNT-1:0] expBin;
    logic [15:0] gap_r;
    logic seen_r;
    always_comb begin
        for (int b = 0; b < BIN_COUNT; b++) begin
            expBin[b] = statInc.goodBytes >= BIN_LO[b] && statInc.goodBytes <= BIN_HI[b];
        end
    end
    // First slot after reset has no reference, so it is skipped
    always_ff @(posedge clk) begin
        gap_r <= (reset || markerSlot) ? 16'h0001 : gap_r + 16'h0001;
        seen_r <= reset ? 1'b0 : (seen_r || markerSlot);
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence endBeatS;
        txBeat.valid && txBeat.eop;
    endsequence
    sequence badEndS;
        endBeatS ##0 txBeat.err;
    endsequence
    // --------------------------------
    // Properties
    // --------------------------------
    pkt_at_end_a: assert property (statInc.totalPkt |-> $past(txBeat.valid && txBeat.eop))
        else $error("packet pulse without frame end");
    bytes_follow_a: assert property (statInc.totalBytes != 5'h00 |->
        $past(txBeat.valid) && statInc.totalBytes == $past(txBeat.bytes))
        else $error("byte increment differs from beat");
    bad_not_good_a: assert property (badEndS |=> !statInc.goodPkt)
        else $error("errored frame counted good");
    good_has_len_a: assert property (statInc.goodPkt |-> statInc.totalPkt
        && statInc.goodBytes != 14'h0000) else $error("good pulse without length");
    good_zero_a: assert property (!statInc.goodPkt |-> statInc.goodBytes == 14'h0000)
        else $error("good bytes outside good frame end");
    hist_once_a: assert property (statInc.hist != 9'h000 |->
        $onehot(statInc.hist) && statInc.totalPkt) else $error("bad histogram pulse");
    hist_bin_a: assert property (statInc.goodPkt |-> statInc.hist == expBin)
        else $error("histogram bin wrong");
    pulse_single_a: assert property (statInc.totalPkt && !(txBeat.valid && txBeat.eop)
        |=> !statInc.totalPkt) else $error("packet pulse too long");
    marker_period_a: assert property (markerSlot && seen_r |-> gap_r == 16'(MARK_PERIOD))
        else $error("marker slot period wrong");
endmodule

bind tsi_tx_stats tsi_tx_stats_props #(.MARK_PERIOD(MARK_PERIOD)) props (.clk(clk),
    .reset(reset), .txBeat(txBeat), .statInc(statInc), .markerSlot(markerSlot));

// File: testbench/tsi_stat_counters.sv
`timescale 1ns/1ns
module tsi_stat_counters
    import tsi_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire tsi_pkg::tsi_stat_s statInc,
    output logic [31:0] pkts,
    output logic [31:0] bytes,
    output logic [31:0] goodPkts,
    output logic [31:0] goodBytes,
    output logic [8:0][31:0] histCnt
);
    // Every cycle is added; a skipped cycle would lose counts
    always_ff @(posedge clk) begin
        if (reset) begin
            pkts <= '0;
            bytes <= '0;
            goodPkts <= '0;
            goodBytes <= '0;
            histCnt <= '0;
        end else begin
            pkts <= pkts + 32'(statInc.totalPkt);
            bytes <= bytes + 32'(statInc.totalBytes);
            goodPkts <= goodPkts + 32'(statInc.goodPkt);
            goodBytes <= goodBytes + 32'(statInc.goodBytes);
            for (int b = 0; b < 9; b++) begin
                histCnt[b] <= histCnt[b] + 32'(statInc.hist[b]);
            end
        end
    end
endmodule

// File: testbench/tsi_tx_stats_bench.sv
`timescale 1ns/1ns
module tsi_tx_stats_bench;
    import tsi_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, markerSlot, rs;
    logic [31:0] hrdata, rd, pkts, bytes, goodPkts, goodBytes;
    logic [8:0][31:0] histCnt;
    tsi_beat_s txBeat = '0;
    tsi_stat_s statInc;
    tsi_lanes_t laneDataOut;
    tsi_lanes_t laneDataIn = {3{64'h5a5a_0f0f_3c3c_9696}};
    int mismatches = 0;
    int total_checks = 0;
    int k, eb, eg, egb;
    int eh[9] = '{default: 0};
    int lens[19] = '{63, 64, 65, 127, 128, 255, 256, 511, 512, 1023, 1024, 1518, 1519,
        1522, 1523, 1548, 1549, 2047, 2048};
    int lo[9] = '{64, 65, 128, 256, 512, 1024, 1519, 1523, 1549};
    int hi[9] = '{64, 127, 255, 511, 1023, 1518, 1522, 1548, 2047};
    always #10 clk = ~clk;
    tsi_tx_stats #(.MARK_PERIOD(8)) DUT (.clk(clk), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .txBeat(txBeat), .statInc(statInc), .laneDataIn(laneDataIn),
        .laneDataOut(laneDataOut), .markerSlot(markerSlot));
    tsi_stat_counters cnt (.clk(clk), .reset(reset), .statInc(statInc), .pkts(pkts),
        .bytes(bytes), .goodPkts(goodPkts), .goodBytes(goodBytes), .histCnt(histCnt));
    // --------------------------------
    // Tasks
    // --------------------------------
    function automatic logic [31:0] mw(input int i);
        return 32'h1000_0000 + 32'(i) * 32'h0101_0101;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        rs = hresp;
    endtask
    task automatic busRd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(64'(rd), 64'(exp), "read");
        chk(64'(rs), 64'(HRESP_OKAY), "response");
    endtask
    // Err rides on every beat so the frame is bad wherever it is sampled
    task automatic sendFrame(input int len, input logic bad);
        int left;
        left = len;
        while (left > 0) begin
            @(posedge clk);
            txBeat <= {1'b1, left <= 16, bad, 5'(left > 16 ? 16 : left)};
            left -= 16;
        end
        @(posedge clk);
        txBeat <= '0;
    endtask
    task results;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        results;
    end
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        busRd(8'h00, 32'h3);
        busRd(8'h40, 32'h0);
        for (int i = 0; i < 6; i++) xfer(1'b1, 8'(16 + 4 * i), mw(i));
        xfer(1'b1, 8'h00, 32'h1);
        xfer(1'b1, 8'h10, 32'hffff_ffff);
        busRd(8'h10, mw(0));
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (markerSlot !== 1'b1 && k < 40);
        for (int l = 0; l < 3; l++) chk(laneDataOut[l], {mw(2*l+1), mw(2*l)}, "marker");
        @(posedge clk);
        for (int l = 0; l < 3; l++) chk(laneDataOut[l], laneDataIn[l], "lane pass");
        $display("test registers and markers done");
        foreach (lens[i]) begin
            sendFrame(lens[i], i % 3 == 1);
            eb += lens[i];
            eg += (i % 3 != 1);
            egb += (i % 3 != 1) ? lens[i] : 0;
            for (int b = 0; b < 9; b++) eh[b] += (lens[i] >= lo[b] && lens[i] <= hi[b]);
        end
        repeat (3) @(posedge clk);
        chk(pkts, 19, "packets");
        chk(bytes, 64'(eb), "bytes");
        chk(goodPkts, 64'(eg), "good packets");
        chk(goodBytes, 64'(egb), "good bytes");
        for (int b = 0; b < 9; b++) chk(histCnt[b], 64'(eh[b]), "bin");
        $display("test frames done");
        xfer(1'b1, 8'h00, 32'h0);
        sendFrame(100, 1'b0);
        repeat (3) @(posedge clk);
        chk(pkts, 19, "pcs packets");
        chk(bytes, 64'(eb), "pcs bytes");
        busRd(8'h04, 32'h0000_0014);
        busRd(8'h08, 32'h0000_0064);
        $display("test pcs mode done");
        results;
    end
endmodule
